// File: hw/enh_pkg.sv
// Purpose: Constants for the enhancement control register block
// Assumes: AXI4-Lite slave, 32-bit data, byte addresses
// Notes: Bit positions and reset value of the control register
package enh_pkg;
   localparam logic [7:0] ADDR_ENH_CTRL = 8'h6C;
   localparam logic [7:0] ADDR_ENH_STATUS = 8'h70;
   localparam logic [7:0] ENH_CTRL_RESET = 8'h00;
   localparam int BIT_LIMIT_BOOST = 7;
   localparam int BIT_FAST_TONE = 6;
   localparam int BIT_CONV_SPEEDUP = 5;
   localparam int BIT_EXT_ZREF = 4;
   localparam int BIT_BAT_DEBOUNCE = 3;
   localparam int BIT_VOLT_LOOP = 2;
   localparam int BIT_CONV_SQUELCH = 1;
   localparam int BIT_LOOP_HYST = 0;
   // Variant masks: generation variant lacks debounce; selection variant lacks speedup and squelch
   localparam logic [7:0] MASK_GEN_VARIANT = 8'hF7;
   localparam logic [7:0] MASK_SEL_VARIANT = 8'hDD;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_FREQ_HZ = 125000000;
   localparam int DEBOUNCE_MS = 60;
   localparam int DEBOUNCE_CYCLES = CLK_FREQ_HZ / 1000 * DEBOUNCE_MS;
   localparam int LIMIT_BOOST_MA = 41;
   localparam int TONE_RATE_FAST_HZ = 24000;
   localparam int TONE_RATE_SLOW_HZ = 8000;
   localparam int TONE_DIV_FAST = CLK_FREQ_HZ / TONE_RATE_FAST_HZ;
   localparam int TONE_DIV_SLOW = CLK_FREQ_HZ / TONE_RATE_SLOW_HZ;
   localparam logic [6:0] FSK_IREG_FIRST = 7'h63;
   localparam logic [6:0] HYST_UPPER_IREG = 7'h1C;
   localparam logic [6:0] HYST_LOWER_IREG = 7'h2B;
endpackage

// File: hw/enh_ctrl.sv
// Purpose: Enhancement enable register with AXI4-Lite access and control outputs
// Assumes: Single clock, synchronous active-high reset, all four pin inputs synchronised here
// Notes: Read at 0x6C, status at 0x70; unmapped addresses answer SLVERR
//
// Function
// [RULE1] The register reads all zeros after reset, so every enhancement starts off.
// [RULE2] The register and its features exist only when the silicon revision is C or later.
// [RULE3] Bit 7 raises the loop current limit to 41 mA after each ring burst, else the programmed limit applies.
// [RULE4] Tone generator 1 runs at 24 kHz when bit 6 and the ringing relay bit are set, else at 8 kHz.
// [RULE5] In that FSK condition tone 1 uses the dedicated FSK oscillator settings, else the standard ones.
// [RULE6] In that FSK condition the oscillator 1 cadence timers step in 41.67 us units.
// [RULE7] Bit 5 switches the converter to the multi-threshold error control algorithm.
// [RULE8] Bit 4 disconnects the internal impedance reference resistor.
// [RULE9] Bit 3 applies a 60 ms debounce only on high-to-low battery switching in external battery mode.
// [RULE10] Debounce exists only on the selection variant; speedup and squelch only on the generation variant.
// [RULE11] Bit 2 selects voltage-based loop closure, else current-based.
// [RULE12] Bit 1 enables squelch of converter noise in the voice band.
// [RULE13] Bit 0 enables loop closure hysteresis with thresholds from indirect registers 28 and 43.
// [RULE14] Writes update all implemented bits at once; unimplemented bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module enh_ctrl
   import enh_pkg::*;
#(
   parameter bit SELECTION_VARIANT = 1'b0,
   parameter bit HAS_ENHANCEMENTS = 1'b1,
   parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ringing_relay_ctrl,
   input wire logic ring_burst_end,
   input wire logic external_battery_select,
   input wire logic bat_switch_req,
   output logic current_limit_boost_en,
   output logic fast_tone_gen_en,
   output logic converter_speedup_en,
   output logic external_impedance_ref_en,
   output logic battery_switch_debounce_en,
   output logic voltage_loop_closure_en,
   output logic converter_squelch_en,
   output logic loop_closure_hysteresis_en,
   output logic current_boost_active,
   output logic tone1_fast_clock,
   output logic tone1_use_fsk_regs,
   output logic tone1_fine_cadence,
   output logic tone1_tick,
   output logic bat_switch_low
);
   localparam logic [7:0] IMPL_MASK = !HAS_ENHANCEMENTS ? 8'h00 :
      (SELECTION_VARIANT ? MASK_SEL_VARIANT : MASK_GEN_VARIANT); // RULE2 RULE10

   // Debounce counter is 24 bits and needs at least two steps
   if (DEBOUNCE_LEN < 2 || DEBOUNCE_LEN > 16777215) begin : g_bad_debounce_len
      $error("DEBOUNCE_LEN out of range");
   end

   logic [7:0] enh_reg;
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         enh_reg <= ENH_CTRL_RESET; // RULE1
      end else if (do_write && aw_addr[7:2] == ADDR_ENH_CTRL[7:2] && w_strb[0]) begin
         enh_reg <= w_data[7:0] & IMPL_MASK; // RULE14
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr[7:2] == ADDR_ENH_CTRL[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Status word: live derived states above the fixed revision-C present flag in bit 0
   logic [31:0] status_word;
   assign status_word = {26'h0, bat_switch_low, current_boost_active, tone1_fine_cadence,
      tone1_use_fsk_regs, tone1_fast_clock, HAS_ENHANCEMENTS};

   // One read in flight; a new address waits for rready
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         if (s_axi_araddr[7:2] == ADDR_ENH_CTRL[7:2]) begin
            s_axi_rdata <= {24'h0, enh_reg};
            s_axi_rresp <= RESP_OKAY;
         end else if (s_axi_araddr[7:2] == ADDR_ENH_STATUS[7:2]) begin
            s_axi_rdata <= status_word;
            s_axi_rresp <= RESP_OKAY;
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign current_limit_boost_en = enh_reg[BIT_LIMIT_BOOST];
   assign fast_tone_gen_en = enh_reg[BIT_FAST_TONE];
   assign converter_speedup_en = enh_reg[BIT_CONV_SPEEDUP]; // RULE7 RULE10
   assign external_impedance_ref_en = enh_reg[BIT_EXT_ZREF]; // RULE8
   assign battery_switch_debounce_en = enh_reg[BIT_BAT_DEBOUNCE];
   assign voltage_loop_closure_en = enh_reg[BIT_VOLT_LOOP]; // RULE11
   assign converter_squelch_en = enh_reg[BIT_CONV_SQUELCH]; // RULE12
   assign loop_closure_hysteresis_en = enh_reg[BIT_LOOP_HYST]; // RULE13

   // Pin synchronisers, three stages each
   logic [2:0] relay_sync, burst_sync, batsel_sync, batreq_sync;
   always_ff @(posedge clk) begin
      if (rst) begin
         relay_sync <= 3'h0;
         burst_sync <= 3'h0;
         batsel_sync <= 3'h0;
         batreq_sync <= 3'h0;
      end else begin
         relay_sync <= {relay_sync[1:0], ringing_relay_ctrl};
         burst_sync <= {burst_sync[1:0], ring_burst_end};
         batsel_sync <= {batsel_sync[1:0], external_battery_select};
         batreq_sync <= {batreq_sync[1:0], bat_switch_req};
      end
   end

   logic relay_s, burst_s, batsel_s, batreq_s;
   always_ff @(posedge clk) begin
      if (rst) begin
         relay_s <= 1'b0;
         burst_s <= 1'b0;
         batsel_s <= 1'b0;
         batreq_s <= 1'b0;
      end else begin
         if (relay_sync[2] == relay_sync[1]) relay_s <= relay_sync[2];
         if (burst_sync[2] == burst_sync[1]) burst_s <= burst_sync[2];
         if (batsel_sync[2] == batsel_sync[1]) batsel_s <= batsel_sync[2];
         if (batreq_sync[2] == batreq_sync[1]) batreq_s <= batreq_sync[2];
      end
   end

   // Boost follows the filtered ring-burst-end input while the flag is set; it clears when either goes low
   always_ff @(posedge clk) begin
      if (rst) begin
         current_boost_active <= 1'b0;
      end else if (!current_limit_boost_en) begin
         current_boost_active <= 1'b0; // RULE3
      end else begin
         current_boost_active <= burst_s; // RULE3
      end
   end

   logic fsk_cond;
   assign fsk_cond = fast_tone_gen_en && relay_s; // RULE4
   assign tone1_fast_clock = fsk_cond; // RULE4
   assign tone1_use_fsk_regs = fsk_cond; // RULE5
   assign tone1_fine_cadence = fsk_cond; // RULE6

   // Reload picks the rate for the whole coming period
   logic [15:0] tone_cnt;
   always_ff @(posedge clk) begin
      if (rst) begin
         tone_cnt <= 16'h0000;
         tone1_tick <= 1'b0;
      end else if (tone_cnt == 16'h0000) begin
         tone_cnt <= fsk_cond ? 16'(TONE_DIV_FAST - 1) : 16'(TONE_DIV_SLOW - 1); // RULE4
         tone1_tick <= 1'b1;
      end else begin
         tone_cnt <= tone_cnt - 16'h0001;
         tone1_tick <= 1'b0;
      end
   end

   // Battery switch: high-to-low debounced only when enabled in external mode
   logic [23:0] db_cnt;
   logic need_db;
   assign need_db = battery_switch_debounce_en && batsel_s && batreq_s && !bat_switch_low;
   always_ff @(posedge clk) begin
      if (rst) begin
         db_cnt <= 24'h000000;
         bat_switch_low <= 1'b0;
      end else if (!batreq_s) begin
         db_cnt <= 24'h000000;
         bat_switch_low <= 1'b0;
      end else if (!need_db) begin
         db_cnt <= 24'h000000;
         bat_switch_low <= 1'b1;
      end else if (db_cnt == 24'(DEBOUNCE_LEN - 1)) begin
         bat_switch_low <= 1'b1; // RULE9
      end else begin
         db_cnt <= db_cnt + 24'h000001; // RULE9
      end
   end

   // Assertions
   sequence s_write_ctrl;
      do_write && aw_addr[7:2] == ADDR_ENH_CTRL[7:2] && w_strb[0];
   endsequence

   sequence s_boost_armed;
      current_limit_boost_en && burst_s;
   endsequence

   a_reset_zero: assert property (@(posedge clk) $past(rst) |-> enh_reg == 8'h00)
      else $error("register not zero after reset"); // RULE1
   a_variant_mask: assert property (@(posedge clk) disable iff (rst) (enh_reg & ~IMPL_MASK) == 8'h00)
      else $error("unimplemented bit set"); // RULE2
   a_write_update: assert property (@(posedge clk) disable iff (rst)
      s_write_ctrl |=> enh_reg == ($past(w_data[7:0]) & IMPL_MASK))
      else $error("write not applied"); // RULE14
   a_boost_off: assert property (@(posedge clk) disable iff (rst)
      !current_limit_boost_en |=> !current_boost_active)
      else $error("boost without enable"); // RULE3
   a_fsk_rate: assert property (@(posedge clk) disable iff (rst)
      tone1_tick |-> tone_cnt == ($past(fsk_cond) ? 16'(TONE_DIV_FAST - 1) : 16'(TONE_DIV_SLOW - 1)))
      else $error("tone period reload wrong"); // RULE4
   a_fsk_regs: assert property (@(posedge clk) disable iff (rst)
      tone1_use_fsk_regs |-> fast_tone_gen_en)
      else $error("fsk regs without enable"); // RULE5
   a_fine_cadence: assert property (@(posedge clk) disable iff (rst)
      tone1_fine_cadence |-> relay_s)
      else $error("fine cadence without relay"); // RULE6
   a_bat_db: assert property (@(posedge clk) disable iff (rst)
      need_db && db_cnt == 24'h000000 |=> !bat_switch_low)
      else $error("debounce skipped"); // RULE9
   a_var_bits: assert property (@(posedge clk) disable iff (rst)
      SELECTION_VARIANT ? (!converter_speedup_en && !converter_squelch_en) : !battery_switch_debounce_en)
      else $error("bit set that this variant lacks"); // RULE10
   a_bresp_follow: assert property (@(posedge clk) disable iff (rst)
      do_write |=> s_axi_bvalid)
      else $error("no write response"); // RULE14
   a_boost_on: assert property (@(posedge clk) disable iff (rst) // RULE3
      s_boost_armed |=> current_boost_active)
      else $error("boost missing after ring burst");
   a_read_resp: assert property (@(posedge clk) disable iff (rst) // RULE14
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read response");
   a_resp_block: assert property (@(posedge clk) disable iff (rst) // RULE14
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_tone_bound: assert property (@(posedge clk) disable iff (rst) // RULE4
      tone_cnt <= 16'(TONE_DIV_SLOW - 1))
      else $error("tone counter out of range");
   a_db_bound: assert property (@(posedge clk) disable iff (rst) // RULE9
      db_cnt <= 24'(DEBOUNCE_LEN - 1))
      else $error("debounce counter out of range");
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the enhancement control register block
// Assumes: Selection variant, revision C present, short debounce length
// Notes: Read and write responses are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import enh_pkg::*;
   logic clk, rst, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, awready, wready, arready;
   logic [7:0] awaddr, araddr, en;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic relay, burst_end, ext_bat, bat_req, boost, fast, fsk_regs, fine, tick, bat_low;
   int mismatches, comparisons, seed, n;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [31:0] d;

   enh_ctrl #(.SELECTION_VARIANT(1'b1), .DEBOUNCE_LEN(20)) i_enh_ctrl (.clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ringing_relay_ctrl(relay), .ring_burst_end(burst_end), .external_battery_select(ext_bat),
      .bat_switch_req(bat_req), .current_limit_boost_en(en[7]), .fast_tone_gen_en(en[6]),
      .converter_speedup_en(en[5]), .external_impedance_ref_en(en[4]),
      .battery_switch_debounce_en(en[3]), .voltage_loop_closure_en(en[2]),
      .converter_squelch_en(en[1]), .loop_closure_hysteresis_en(en[0]),
      .current_boost_active(boost), .tone1_fast_clock(fast), .tone1_use_fsk_regs(fsk_regs),
      .tone1_fine_cadence(fine), .tone1_tick(tick), .bat_switch_low(bat_low));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Handshakes are judged at the falling edge; ready cannot change before the next rising edge
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] e);
      logic ta, tw;
      bq.push_back(e);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge clk);
         ta = awready;
         tw = wready;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while ((awvalid && !ta) || (wvalid && !tw));
      do begin
         @(negedge clk);
         ta = bvalid;
         @(posedge clk);
      end while (!ta);
   endtask

   task rd(input logic [7:0] a, input logic [33:0] e);
      logic t;
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge clk);
         t = arready;
         @(posedge clk);
      end while (!t);
      arvalid <= 1'b0;
      do begin
         @(negedge clk);
         t = rvalid;
         @(posedge clk);
      end while (!t);
   endtask

   task tick_gap;
      n = 0;
      do @(negedge clk); while (tick !== 1'b1);
      do begin
         @(negedge clk);
         n++;
      end while (tick !== 1'b1);
      @(posedge clk);
   endtask

   always @(negedge clk) begin
      if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
      if (bvalid && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()});
   end

   initial begin
      #(8 * 80000);
      mismatches++;
      give_verdict;
   end

   initial begin
      {rst, awvalid, wvalid, arvalid, bready, rready} = 6'h21;
      {relay, burst_end, ext_bat, bat_req} = 4'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      seed = 26;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      bready <= 1'b1;
      rready <= 1'b1;
      rd(ADDR_ENH_CTRL, {RESP_OKAY, 32'h0});
      rd(ADDR_ENH_STATUS, {RESP_OKAY, 32'h1});
      check({26'h0, en}, {26'h0, ENH_CTRL_RESET});
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         d = (i == 0) ? 32'hFF : (i == 1) ? 32'h0 : $random(seed);
         wr(ADDR_ENH_CTRL, d, 4'hF, RESP_OKAY);
         rd(ADDR_ENH_CTRL, {RESP_OKAY, 24'h0, d[7:0] & MASK_SEL_VARIANT});
         check({26'h0, en}, {26'h0, d[7:0] & MASK_SEL_VARIANT});
      end
      $display("test register bits done");
      wr(ADDR_ENH_CTRL, ~d, 4'h0, RESP_OKAY);
      rd(ADDR_ENH_CTRL, {RESP_OKAY, 24'h0, d[7:0] & MASK_SEL_VARIANT});
      wr(8'h40, 32'hFF, 4'hF, RESP_SLVERR);
      rd(8'h40, {RESP_SLVERR, 32'h0});
      $display("test refusals done");
      wr(ADDR_ENH_CTRL, 32'hC0, 4'hF, RESP_OKAY);
      relay <= 1'b1;
      repeat (8) @(posedge clk);
      check({31'h0, fast, fsk_regs, fine}, 34'h7);
      tick_gap;
      check(n, TONE_DIV_FAST);
      relay <= 1'b0;
      repeat (8) @(posedge clk);
      check({31'h0, fast, fsk_regs, fine}, 34'h0);
      tick_gap;
      check(n, TONE_DIV_SLOW);
      $display("test tone rate done");
      burst_end <= 1'b1;
      repeat (8) @(posedge clk);
      check(boost, 1'b1);
      wr(ADDR_ENH_CTRL, 32'h40, 4'hF, RESP_OKAY);
      @(negedge clk);
      check(boost, 1'b0);
      ext_bat <= 1'b1;
      bat_req <= 1'b1;
      repeat (8) @(posedge clk);
      check(bat_low, 1'b1);
      bat_req <= 1'b0;
      repeat (8) @(posedge clk);
      check(bat_low, 1'b0);
      wr(ADDR_ENH_CTRL, 32'h48, 4'hF, RESP_OKAY);
      bat_req <= 1'b1;
      repeat (8) @(posedge clk);
      check(bat_low, 1'b0);
      repeat (20) @(posedge clk);
      check(bat_low, 1'b1);
      $display("test boost and battery done");
      give_verdict;
   end
endmodule
`default_nettype wire
